//--- core/hwr_ctrl.sv
/*
 * Halt, wake-up and reset controller of a small microcontroller.
 * Assumes the core pulses HALT_REQ / WDOG_CLR_INSTR for one cycle, the
 * watchdog pulses WDOG_OVF, and the external init pin is synchronous.
 */
`timescale 1ns/1ps
// Summary of operation
// - halt stops the system oscillator; watchdog oscillator runs when selected.
// - while halted, core state and port levels are frozen.
// - entering halt clears the watchdog when it runs from its own oscillator.
// - halt sets the power-down flag and clears the timeout flag.
// - halt ends on external reset, interrupt, port A fall or watchdog overflow.
// - power-down flag cleared at power-up and by the watchdog clear instruction.
// - watchdog overflow in halt is a warm reset, timeout flag set.
// - a watchdog time-out in run or halt sets the timeout flag.
// - external reset always performs a full initialization.
// - each port A bit enables wake; port wake resumes at next instruction.
// - interrupt wake resumes next if disabled or stack full, else interrupts.
// - an interrupt already pending at halt entry cannot wake the device.
// - every wake waits 1024 system clocks before resuming.
// - power-up waits 1024 system clocks for the oscillator.
// - timeout and power-down flags encode the reset cause.
// - chip reset initializes core state; watchdog cleared, then counts.
// - watchdog overflow in normal run performs full reset, sets timeout.
module hwr_ctrl #(
	parameter int PORT_W = 8,
	parameter int INT_W = 5,
	parameter int WDOG_DIV = hwr_pkg::WDOG_TICK_CYCLES,
	parameter int STARTUP = hwr_pkg::STARTUP_CYCLES
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// core
	input wire logic HALT_REQ,
	input wire logic WDOG_CLR_INSTR,
	input wire logic [INT_W-1:0] INT_REQ,
	input wire logic [INT_W-1:0] INT_EN,
	input wire logic INT_MASTER_EN,
	input wire logic STACK_FULL,
	output logic CORE_HOLD,
	output logic FULL_RESET,
	output logic WARM_RESET,
	output logic RESUME_NEXT,
	output logic INT_RESPONSE,
	output logic PORT_HOLD,
	// watchdog and oscillators
	input wire logic WDOG_OVF,
	output logic WDOG_CLEAR,
	output logic SYS_OSC_EN,
	output logic WDOG_OSC_RUN,
	// pins
	input wire logic EXTERNAL_INIT_PIN_N,
	input wire logic [PORT_W-1:0] PORTA_IN,
	// status
	output logic WATCHDOG_TIMEOUT_FLAG,
	output logic POWER_DOWN_FLAG,
	output logic IRQ
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	localparam int DW = $clog2(WDOG_DIV + 1);
	localparam int HW = $clog2(STARTUP + 1);

	hwr_pkg::hwr_state_t state_q, state_d;
	hwr_pkg::hwr_wake_t kind_q, kind_d;
	logic from_halt_q, from_halt_d;
	logic [INT_W-1:0] pend_at_halt_q;
	logic to_q, pdf_q;
	logic [PORT_W-1:0] wake_en_q;
	logic wosc_sel_q, wtick_q, port_fall, dly_done, dly_start, ext_low, rd_take, acc_wr_q;
	logic [hwr_pkg::EVT_W-1:0] evt_q, evt_mask_q, evt_set, evt_clr;
	logic [DW-1:0] div_q;
	logic ev_halt, ev_ext_halt, ev_wdt_run, ev_wdt_halt, ev_int_wake, ev_port_wake;
	logic [INT_W-1:0] int_wake_src;
	logic [7:0] acc_addr_q;

	// highest priority source: lowest index set
	function automatic logic [INT_W-1:0] lowest(input logic [INT_W-1:0] v);
		lowest = v & (~v + INT_W'(1));
	endfunction

	// ------------------------------------------------------------
	// watchdog oscillator tick and port wake
	// ------------------------------------------------------------
	// without its own oscillator the port is sampled every system clock
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			div_q <= '0;
			wtick_q <= 1'b0;
		end else if (!wosc_sel_q || div_q == DW'(WDOG_DIV - 1)) begin
			div_q <= '0;
			wtick_q <= 1'b1;
		end else begin
			div_q <= div_q + DW'(1);
			wtick_q <= 1'b0;
		end
	end

	hwr_port_wake #(.W(PORT_W)) u_port_wake (
		.clk(CLK), .rst(RST), .tick(wtick_q),
		.pins(PORTA_IN), .enable(wake_en_q), .fall_q(port_fall)
	);

	hwr_startup_timer #(.CYCLES(STARTUP)) u_startup (
		.clk(CLK), .rst(RST), .start(dly_start), .done(dly_done)
	);

	// ------------------------------------------------------------
	// events and sequencer
	// ------------------------------------------------------------
	assign ext_low = !EXTERNAL_INIT_PIN_N;
	assign int_wake_src = lowest(INT_REQ & ~pend_at_halt_q);
	assign ev_halt = (state_q == hwr_pkg::ST_RUN) && !ext_low && !WDOG_OVF && HALT_REQ;
	assign ev_wdt_run = (state_q == hwr_pkg::ST_RUN) && !ext_low && WDOG_OVF;
	assign ev_ext_halt = (state_q == hwr_pkg::ST_HALT) && ext_low;
	assign ev_wdt_halt = (state_q == hwr_pkg::ST_HALT) && !ext_low && WDOG_OVF;
	assign ev_int_wake = (state_q == hwr_pkg::ST_HALT) && !ext_low && !WDOG_OVF
		&& (|int_wake_src);
	assign ev_port_wake = (state_q == hwr_pkg::ST_HALT) && !ext_low && !WDOG_OVF
		&& !(|int_wake_src) && port_fall;
	assign dly_start = (state_d == hwr_pkg::ST_WAKE) && (state_q != hwr_pkg::ST_WAKE);

	always_comb begin
		state_d = state_q;
		kind_d = kind_q;
		from_halt_d = from_halt_q;
		if (ext_low && state_q != hwr_pkg::ST_EXT) begin
			state_d = hwr_pkg::ST_EXT;
			kind_d = hwr_pkg::WK_NONE;
			from_halt_d = (state_q == hwr_pkg::ST_HALT);
		end else begin
			unique case (state_q)
				hwr_pkg::ST_POR: if (dly_done) state_d = hwr_pkg::ST_RUN;
				hwr_pkg::ST_RUN: if (ev_halt) state_d = hwr_pkg::ST_HALT;
				hwr_pkg::ST_HALT: begin
					if (ev_wdt_halt || ev_int_wake || ev_port_wake) begin
						state_d = hwr_pkg::ST_WAKE;
					end
					if (ev_int_wake && INT_MASTER_EN && |(int_wake_src & INT_EN) && !STACK_FULL) begin
						kind_d = hwr_pkg::WK_INT;
					end else if (ev_int_wake || ev_port_wake) begin
						kind_d = hwr_pkg::WK_NEXT;
					end else if (ev_wdt_halt) begin
						kind_d = hwr_pkg::WK_NONE;
					end
				end
				hwr_pkg::ST_WAKE: if (dly_done) state_d = hwr_pkg::ST_RUN;
				// only a wake from halt pays the start-up delay
				hwr_pkg::ST_EXT: if (!ext_low) state_d = from_halt_q ? hwr_pkg::ST_WAKE : hwr_pkg::ST_RUN;
				default: state_d = hwr_pkg::ST_POR;
			endcase
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_q <= hwr_pkg::ST_POR;
			kind_q <= hwr_pkg::WK_NONE;
			from_halt_q <= 1'b0;
		end else begin
			state_q <= state_d;
			kind_q <= kind_d;
			from_halt_q <= from_halt_d;
		end
	end

	// requests already raised at halt entry lose their wake power
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			pend_at_halt_q <= '0;
		end else if (ev_halt) begin
			pend_at_halt_q <= INT_REQ;
		end
	end

	// ------------------------------------------------------------
	// reset-cause flags
	// ------------------------------------------------------------
	// set beats clear when a time-out meets a clearing event
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			to_q <= 1'b0;
			pdf_q <= 1'b0;
		end else begin
			if (ev_wdt_run || ev_wdt_halt) to_q <= 1'b1;
			else if (ev_halt || ev_ext_halt) to_q <= 1'b0;
			// a time-out or init pin in run must leave the power-down flag alone
			if (ev_halt || ev_ext_halt || ev_wdt_halt) begin
				pdf_q <= 1'b1;
			end else if (WDOG_CLR_INSTR && state_q == hwr_pkg::ST_RUN && !ext_low && !WDOG_OVF) begin
				pdf_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// outputs to core, watchdog and oscillators
	// ------------------------------------------------------------
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			SYS_OSC_EN <= 1'b1;
			CORE_HOLD <= 1'b1;
			PORT_HOLD <= 1'b0;
			FULL_RESET <= 1'b1;
			WARM_RESET <= 1'b0;
			WDOG_CLEAR <= 1'b1;
			RESUME_NEXT <= 1'b0;
			INT_RESPONSE <= 1'b0;
			WDOG_OSC_RUN <= hwr_pkg::CTRL_WOSC_RST;
		end else begin
			SYS_OSC_EN <= (state_d != hwr_pkg::ST_HALT);
			WDOG_OSC_RUN <= wosc_sel_q;
			CORE_HOLD <= (state_d != hwr_pkg::ST_RUN);
			PORT_HOLD <= (state_d == hwr_pkg::ST_HALT);
			FULL_RESET <= (state_d == hwr_pkg::ST_POR) || (state_d == hwr_pkg::ST_EXT)
				|| ev_wdt_run;
			WARM_RESET <= ev_wdt_halt;
			// cleared while reset is held, counts once it lets go
			WDOG_CLEAR <= (state_d == hwr_pkg::ST_POR) || (state_d == hwr_pkg::ST_EXT)
				|| ev_wdt_run || (ev_halt && wosc_sel_q);
			RESUME_NEXT <= (state_q == hwr_pkg::ST_WAKE) && dly_done
				&& (kind_q == hwr_pkg::WK_NEXT);
			INT_RESPONSE <= (state_q == hwr_pkg::ST_WAKE) && dly_done
				&& (kind_q == hwr_pkg::WK_INT);
		end
	end

	assign WATCHDOG_TIMEOUT_FLAG = to_q;
	assign POWER_DOWN_FLAG = pdf_q;

	// ------------------------------------------------------------
	// event status and interrupt
	// ------------------------------------------------------------
	assign evt_set = {ev_wdt_run, ev_ext_halt, ev_wdt_halt, ev_int_wake, ev_port_wake};
	assign rd_take = HSEL && HREADY && HTRANS[1] && !HWRITE;
	assign evt_clr = (rd_take && HADDR[7:0] == hwr_pkg::OFS_EVT) ? '1 : '0;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			evt_q <= '0;
			IRQ <= 1'b0;
		end else begin
			evt_q <= (evt_q & ~evt_clr) | evt_set;
			IRQ <= |(((evt_q & ~evt_clr) | evt_set) & evt_mask_q);
		end
	end

	// ------------------------------------------------------------
	// AHB-Lite slave, zero wait states
	// ------------------------------------------------------------
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			acc_wr_q <= 1'b0;
			acc_addr_q <= 8'h00;
			HRDATA <= 32'h0000_0000;
		end else begin
			acc_wr_q <= HSEL && HREADY && HTRANS[1] && HWRITE;
			if (HSEL && HREADY && HTRANS[1]) begin
				acc_addr_q <= HADDR[7:0];
			end
			HRDATA <= 32'h0000_0000;
			if (rd_take) begin
				unique case (HADDR[7:0])
					hwr_pkg::OFS_CTRL: begin
						HRDATA[hwr_pkg::CTRL_WAKE_LSB +: hwr_pkg::CTRL_WAKE_W] <= wake_en_q;
						HRDATA[hwr_pkg::CTRL_WOSC_BIT] <= wosc_sel_q;
					end
					hwr_pkg::OFS_STATUS: begin
						HRDATA[hwr_pkg::ST_TO_BIT] <= to_q;
						HRDATA[hwr_pkg::ST_PDF_BIT] <= pdf_q;
						HRDATA[hwr_pkg::ST_STATE_LSB +: 3] <= state_q;
					end
					hwr_pkg::OFS_EVT: HRDATA[hwr_pkg::EVT_W-1:0] <= evt_q;
					hwr_pkg::OFS_MASK: HRDATA[hwr_pkg::EVT_W-1:0] <= evt_mask_q;
					default: HRDATA <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			wake_en_q <= hwr_pkg::CTRL_WAKE_RST;
			wosc_sel_q <= hwr_pkg::CTRL_WOSC_RST;
			evt_mask_q <= hwr_pkg::EVT_MASK_RST;
		end else if (acc_wr_q) begin
			if (acc_addr_q == hwr_pkg::OFS_CTRL) begin
				wake_en_q <= HWDATA[hwr_pkg::CTRL_WAKE_LSB +: hwr_pkg::CTRL_WAKE_W];
				wosc_sel_q <= HWDATA[hwr_pkg::CTRL_WOSC_BIT];
			end
			if (acc_addr_q == hwr_pkg::OFS_MASK) evt_mask_q <= HWDATA[hwr_pkg::EVT_W-1:0];
		end
	end

	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic [HW-1:0] hold_cnt_q;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			hold_cnt_q <= '0;
		end else if (state_q != state_d) begin
			hold_cnt_q <= '0;
		end else if (state_q == hwr_pkg::ST_WAKE || state_q == hwr_pkg::ST_POR) begin
			hold_cnt_q <= hold_cnt_q + HW'(1);
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	AST_HALT_OSC: assert property ((state_q == hwr_pkg::ST_HALT) |-> !SYS_OSC_EN && PORT_HOLD)
		else $error("system oscillator or ports not frozen in halt");
	AST_HALT_WDCLR: assert property (ev_halt && wosc_sel_q |=> WDOG_CLEAR && CORE_HOLD)
		else $error("halt entry did not clear watchdog");
	AST_HALT_FLAGS: assert property (ev_halt |=> pdf_q && !to_q)
		else $error("halt entry flags wrong");
	AST_CLR_PDF: assert property (state_q == hwr_pkg::ST_RUN && WDOG_CLR_INSTR
		&& !HALT_REQ && !ext_low && !WDOG_OVF |=> !pdf_q)
		else $error("clear instruction left power-down flag set");
	AST_WDT_WARM: assert property (ev_wdt_halt |=> WARM_RESET && !FULL_RESET && to_q
		&& pdf_q ##1 !WARM_RESET)
		else $error("watchdog halt wake not a one-cycle warm reset");
	AST_WDT_RUN: assert property (ev_wdt_run |=> FULL_RESET && to_q && $stable(pdf_q))
		else $error("watchdog overflow in run mishandled");
	AST_EXT_RST: assert property (ext_low |=> FULL_RESET && CORE_HOLD)
		else $error("external reset not full initialization");
	AST_EXT_HALT: assert property (ev_ext_halt |=> !to_q && pdf_q)
		else $error("external wake flags wrong");
	AST_PEND_BLOCK: assert property (state_q == hwr_pkg::ST_HALT && !ext_low && !WDOG_OVF
		&& !port_fall && ((INT_REQ & ~pend_at_halt_q) == '0) |=> state_q == hwr_pkg::ST_HALT)
		else $error("pending interrupt woke the device");
	AST_DELAY: assert property ((state_q == hwr_pkg::ST_WAKE
		|| state_q == hwr_pkg::ST_POR) && dly_done |-> hold_cnt_q == HW'(STARTUP - 1))
		else $error("start-up delay length wrong");
	AST_RESUME: assert property (ev_port_wake |=> state_q == hwr_pkg::ST_WAKE
		&& kind_q == hwr_pkg::WK_NEXT)
		else $error("port wake does not resume next instruction");

	COV_PORT_WAKE: cover property (hold_cnt_q == HW'(STARTUP - 1) ##1 RESUME_NEXT);
	COV_INT_RESP: cover property (hold_cnt_q == HW'(STARTUP - 1) ##1 INT_RESPONSE);
	COV_WARM: cover property (ev_wdt_halt);
	COV_EXT_HALT: cover property (ev_ext_halt);

endmodule // hwr_ctrl

//--- core/hwr_pkg.sv
/*
 * Shared constants and types of the halt, wake and reset controller:
 * register offsets, field positions, reset values, delay counts, states.
 * Assumes a 40 MHz system clock and a 32-bit AHB-Lite register port.
 */
package hwr_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int WDOG_OSC_PERIOD_NS = 65000;
	// rounded down: the watchdog oscillator is only approximate anyway
	localparam int WDOG_TICK_CYCLES = WDOG_OSC_PERIOD_NS / CLK_PERIOD_NS;
	localparam int STARTUP_CYCLES = 1024;

	// ------------------------------------------------------------
	// register map (byte offsets)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_EVT = 8'h08;
	localparam logic [7:0] OFS_MASK = 8'h0C;

	localparam int CTRL_WAKE_LSB = 0;
	localparam int CTRL_WAKE_W = 8;
	localparam int CTRL_WOSC_BIT = 8;
	localparam logic [7:0] CTRL_WAKE_RST = 8'h00;
	localparam logic CTRL_WOSC_RST = 1'b1;

	localparam int ST_TO_BIT = 0;
	localparam int ST_PDF_BIT = 1;
	localparam int ST_STATE_LSB = 4;

	localparam int EV_PORT = 0;
	localparam int EV_INT = 1;
	localparam int EV_WDT_HALT = 2;
	localparam int EV_EXT = 3;
	localparam int EV_WDT_RUN = 4;
	localparam int EVT_W = 5;
	localparam logic [4:0] EVT_MASK_RST = 5'h00;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_POR = 3'b000,
		ST_RUN = 3'b001,
		ST_HALT = 3'b010,
		ST_WAKE = 3'b011,
		ST_EXT = 3'b100
	} hwr_state_t;

	typedef enum logic [1:0] {
		WK_NONE = 2'b00,
		WK_NEXT = 2'b01,
		WK_INT = 2'b10
	} hwr_wake_t;

endpackage

//--- core/hwr_startup_timer.sv
/*
 * Start-up delay timer: counts a fixed number of system clocks.
 * Assumes start is a one-cycle pulse; busy out of reset for the power-up delay.
 */
`timescale 1ns/1ps
module hwr_startup_timer #(
	parameter int CYCLES = hwr_pkg::STARTUP_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic start,
	output logic done
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] cnt_q;
	logic busy_q;

	assign done = busy_q && (cnt_q == LAST);

	// busy out of reset: power-up must wait the full delay too
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_q <= 1'b1;
			cnt_q <= '0;
		end else if (start) begin
			busy_q <= 1'b1;
			cnt_q <= '0;
		end else if (done) begin
			busy_q <= 1'b0;
		end else if (busy_q) begin
			cnt_q <= cnt_q + CW'(1);
		end
	end

endmodule // hwr_startup_timer

//--- core/hwr_port_wake.sv
/*
 * Port A falling-edge wake detector, sampled on each tick (watchdog rate, or every clock without the watchdog oscillator).
 * Assumes pins synchronous to the clock; tick is a one-cycle enable.
 */
`timescale 1ns/1ps
module hwr_port_wake #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// sampling
	input wire logic tick,
	input wire logic [W-1:0] pins,
	input wire logic [W-1:0] enable,
	output logic fall_q
);
	logic [W-1:0] prev_q;

	// idle-high port pins assumed at reset, so no false edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_q <= '1;
			fall_q <= 1'b0;
		end else begin
			fall_q <= 1'b0;
			if (tick) begin
				prev_q <= pins;
				fall_q <= |(prev_q & ~pins & enable);
			end
		end
	end

endmodule // hwr_port_wake

//--- tb/hwr_wdog_model.sv
/*
 * Behavioural watchdog counter standing beside the halt and reset controller.
 * Assumes the bench enables counting and the controller drives the clear.
 */
`timescale 1ns/1ps
module hwr_wdog_model #(
	parameter int LIMIT = 40
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic run,
	input wire logic clear,
	output logic ovf
);
	int cnt_q;

	// ------------------------------------------------------------
	// counter
	// ------------------------------------------------------------
	// short limit: a real time-out would dominate the run
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 0;
			ovf <= 1'b0;
		end else if (clear) begin
			cnt_q <= 0;
			ovf <= 1'b0;
		end else if (run) begin
			ovf <= (cnt_q == LIMIT - 1);
			cnt_q <= (cnt_q == LIMIT - 1) ? 0 : cnt_q + 1;
		end else begin
			ovf <= 1'b0;
		end
	end
endmodule // hwr_wdog_model

//--- tb/tb_top.sv
/*
 * Self-checking bench of the halt, wake and reset controller.
 * Assumes hwr_wdog_model as the watchdog; core, pins and bus are driven here.
 */
`timescale 1ns/1ps
module tb_top;
	localparam int SU = 16;
	localparam int WD = 4;
	logic clk, rst, hsel, hwrite, hreadyout, hresp, halt_req, clr_instr, master_en, stack_full;
	logic core_hold, full_reset, warm_reset, resume_next, int_response, port_hold, wd_run;
	logic wdog_ovf, wdog_clear, sys_osc_en, wdog_osc_run, init_pin_n, to_flag, pd_flag, irq;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [4:0] int_req, int_en;
	logic [7:0] porta;
	int err_total, compares, n, seed, exp_to, exp_pdf, evt_m, b, k;

	hwr_ctrl #(.PORT_W(8), .INT_W(5), .WDOG_DIV(WD), .STARTUP(SU)) hwr_ctrl_i (
		.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
		.HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
		.HREADYOUT(hreadyout), .HRESP(hresp), .HALT_REQ(halt_req), .WDOG_CLR_INSTR(clr_instr),
		.INT_REQ(int_req), .INT_EN(int_en), .INT_MASTER_EN(master_en), .STACK_FULL(stack_full),
		.CORE_HOLD(core_hold), .FULL_RESET(full_reset), .WARM_RESET(warm_reset),
		.RESUME_NEXT(resume_next), .INT_RESPONSE(int_response), .PORT_HOLD(port_hold),
		.WDOG_OVF(wdog_ovf), .WDOG_CLEAR(wdog_clear), .SYS_OSC_EN(sys_osc_en),
		.WDOG_OSC_RUN(wdog_osc_run), .EXTERNAL_INIT_PIN_N(init_pin_n), .PORTA_IN(porta),
		.WATCHDOG_TIMEOUT_FLAG(to_flag), .POWER_DOWN_FLAG(pd_flag), .IRQ(irq));
	hwr_wdog_model #(.LIMIT(40)) hwr_wdog_model_i (.clk(clk), .rst(rst), .run(wd_run),
		.clear(wdog_clear), .ovf(wdog_ovf));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task c1(input string nm, input logic seen, input logic exp);
		chk(nm, {31'h0, seen}, {31'h0, exp});
	endtask
	task results();
		if (err_total == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// address phase held until ready, then data phase held until ready
	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, rd, e);
		c1("bus response", hresp, 1'b0);
	endtask
	task step(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	task run_wait();
		n = 0;
		do begin
			step(1);
			n++;
		end while (core_hold !== 1'b0 && n < 3000);
	endtask
	task flags();
		c1("timeout flag", to_flag, exp_to[0]);
		c1("power-down flag", pd_flag, exp_pdf[0]);
	endtask
	task halt(input logic wosc);
		@(posedge clk);
		halt_req <= 1'b1;
		@(posedge clk);
		halt_req <= 1'b0;
		#1;
		exp_pdf = 1;
		exp_to = 0;
		flags();
		c1("osc enable", sys_osc_en, 1'b0);
		c1("port hold", port_hold, 1'b1);
		c1("wdog clear", wdog_clear, wosc);
	endtask

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		seed = 32'h4A89;
		err_total = 0;
		compares = 0;
		rst = 1'b1;
		{hsel, hwrite, halt_req, clr_instr, stack_full, wd_run} = 6'h00;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'h0;
		int_req = 5'h00;
		int_en = 5'h1F;
		master_en = 1'b1;
		init_pin_n = 1'b1;
		porta = 8'hFF;
		{exp_to, exp_pdf, evt_m} = {32'h0, 32'h0, 32'h0};
		#20;
		c1("hold in reset", core_hold, 1'b1);
		c1("init in reset", full_reset, 1'b1);
		flags();
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		run_wait();
		chk("power-up delay", n, SU);
		flags();
		rchk("ctrl", hwr_pkg::OFS_CTRL, 32'h100);
		rchk("status", hwr_pkg::OFS_STATUS, 32'h10);
		rchk("unmapped", 8'h10, 32'h0);
		bus(1'b1, hwr_pkg::OFS_STATUS, 32'hFFFF_FFFF);
		rchk("status ro", hwr_pkg::OFS_STATUS, 32'h10);
		k = $random(seed);
		bus(1'b1, hwr_pkg::OFS_MASK, k);
		rchk("mask", hwr_pkg::OFS_MASK, k & 32'h1F);
		bus(1'b1, hwr_pkg::OFS_MASK, 32'h1F);
		bus(1'b1, hwr_pkg::OFS_CTRL, 32'h101);
		c1("wdog osc", wdog_osc_run, 1'b1);
		// one normal response and three ways to fall back to the next instruction
		for (k = 0; k < 4; k++) begin
			master_en <= (k != 1);
			int_en <= (k == 2) ? 5'h00 : 5'h1F;
			stack_full <= (k == 3);
			b = {$random(seed)} % 5;
			halt(1'b1);
			@(posedge clk);
			int_req <= 5'h01 << b;
			run_wait();
			chk("int wake delay", n, SU + 1);
			c1("int response", int_response, k == 0);
			c1("resume next", resume_next, k != 0);
			int_req <= 5'h00;
			evt_m |= 2;
		end
		int_req <= 5'h01;
		halt(1'b1);
		porta <= 8'hFD;
		step(3 * WD * 4);
		c1("pending int held", core_hold, 1'b1);
		c1("disabled port held", sys_osc_en, 1'b0);
		@(posedge clk);
		porta <= 8'hFC;
		run_wait();
		c1("port wake delay", n >= SU + 1 && n <= SU + 2 * WD + 3, 1'b1);
		c1("port resume", resume_next, 1'b1);
		porta <= 8'hFF;
		int_req <= 5'h00;
		bus(1'b1, hwr_pkg::OFS_CTRL, 32'h001);
		step(1);
		c1("wdog osc off", wdog_osc_run, 1'b0);
		halt(1'b0);
		@(posedge clk);
		porta <= 8'hFE;
		run_wait();
		c1("port wake no osc", n >= SU + 1 && n <= SU + 4, 1'b1);
		porta <= 8'hFF;
		evt_m |= 1;
		bus(1'b1, hwr_pkg::OFS_CTRL, 32'h101);
		c1("irq", irq, 1'b1);
		rchk("events", hwr_pkg::OFS_EVT, evt_m);
		step(1);
		c1("irq cleared", irq, 1'b0);
		evt_m = 0;
		wd_run <= 1'b1;
		for (n = 0; n < 200 && full_reset !== 1'b1; n++) step(1);
		wd_run <= 1'b0;
		c1("run overflow init", full_reset, 1'b1);
		c1("warm in run", warm_reset, 1'b0);
		exp_to = 1;
		flags();
		step(1);
		c1("init pulse", full_reset, 1'b0);
		evt_m |= 16;
		@(posedge clk);
		clr_instr <= 1'b1;
		@(posedge clk);
		clr_instr <= 1'b0;
		step(1);
		exp_pdf = 0;
		flags();
		wd_run <= 1'b1;
		halt(1'b1);
		for (n = 0; n < 200 && warm_reset !== 1'b1; n++) step(1);
		wd_run <= 1'b0;
		c1("warm reset", warm_reset, 1'b1);
		c1("no init", full_reset, 1'b0);
		exp_to = 1;
		flags();
		run_wait();
		c1("warm wake delay", n >= SU - 1 && n <= SU + 2, 1'b1);
		c1("no resume", resume_next | int_response, 1'b0);
		evt_m |= 4;
		init_pin_n <= 1'b0;
		step(2);
		c1("ext init", full_reset, 1'b1);
		c1("ext wdog clear", wdog_clear, 1'b1);
		flags();
		init_pin_n <= 1'b1;
		run_wait();
		c1("ext run no delay", n <= 4, 1'b1);
		halt(1'b1);
		init_pin_n <= 1'b0;
		step(2);
		exp_to = 0;
		flags();
		c1("ext halt init", full_reset, 1'b1);
		init_pin_n <= 1'b1;
		run_wait();
		c1("ext wake delay", n >= SU && n <= SU + 4, 1'b1);
		evt_m |= 8;
		rchk("status end", hwr_pkg::OFS_STATUS, 32'h10 | (exp_pdf << 1) | exp_to);
		rchk("events end", hwr_pkg::OFS_EVT, evt_m);
		results();
	end

	// a hung wait ends here instead of running forever
	initial begin
		#750000;
		err_total++;
		results();
	end
endmodule // tb_top
